// *** headphone_amp_power_mode_control_tb.sv ***
// Self-checking bench for the power and mode controller.
// Assumes the host model drives the register side; analog pins from here.
`timescale 1ns/1ps
`include "hp_power_defs.svh"

module headphone_amp_power_mode_control_tb;
   localparam int SHUT_C = 20;
   localparam int STEP_C = 4;
   localparam int HOLD_C = 8;

   logic                              clock;
   logic                              srst;
   logic                              write_strobe;
   logic                              read_strobe;
   logic [7:0]                        reg_address;
   logic [7:0]                        write_data;
   logic [7:0]                        read_data;
   logic                              busy;
   logic                              thermal, supply_ok, above_low;
   logic                              at_high, peak, zero;
   logic                              pd, rail, ss_active;
   hp_power_pkg::channel_ctrl_type    chan;
   hp_power_pkg::current_limit_type   limit;
   hp_power_pkg::switch_drive_type    sw;
   logic [7:0]                        exp_q[$];
   logic                              rd_seen = 1'b0;
   logic [7:0]                        m, d, e;
   logic [2:0]                        pins[6] = '{3'b100, 3'b000, 3'b010,
                                                 3'b001, 3'b100, 3'b101};
   logic [2:0]                        swx[6]  = '{3'b001, 3'b100, 3'b010,
                                                 3'b100, 3'b010, 3'b001};
   int                                failures = 0;
   int                                num_checks = 0;
   int                                cycles = 0;
   int                                busy_run = 0;
   int                                n;

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   hp_power_ctrl #(.SHUTDOWN_CYCLES(SHUT_C), .STEP_CYCLES(STEP_C),
                   .HOLD_CYCLES(HOLD_C)) dut_u (
      .clock(clock), .srst(srst), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .reg_address(reg_address),
      .write_data(write_data), .read_data(read_data), .busy(busy),
      .thermal_active_pin(thermal), .supply_ok_pin(supply_ok),
      .output_above_low_pin(above_low), .output_at_high_pin(at_high),
      .pulse_mode_peak_current(peak), .zero_current_pin(zero),
      .global_power_down(pd), .channel_ctrl(chan),
      .high_rail_select(rail), .current_limit(limit),
      .soft_start_active(ss_active), .switch_drive(sw));

   reg_host_model host_u (
      .clock(clock), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .reg_address(reg_address),
      .write_data(write_data), .busy(busy));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      host_u.access(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_u.access(1'b1, a, v);
   endtask

   task automatic settle;
      repeat (5) @(negedge clock);
   endtask

   // Read results are compared one cycle after the strobe
   always @(posedge clock) rd_seen <= read_strobe;
   always @(negedge clock) if (rd_seen) check(read_data, exp_q.pop_front());

   always @(posedge clock) begin
      if (busy === 1'b1) busy_run <= busy_run + 1;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      {thermal, supply_ok, above_low} = 3'b010;
      {at_high, peak, zero} = 3'b100;
      void'($urandom(32'h269e));
      repeat (4) @(negedge clock);
      srst = 1'b0;
      // Reset values and fixed locations
      check(pd, 1'b1);
      check({chan.left_mute, chan.right_mute}, 2'b11);
      rd(`ADDR_MODE_CONTROL, 8'h01);
      rd(`ADDR_VOLUME_SILENCE, 8'hc0);
      rd(`ADDR_OUTPUT_OPTIONS, 8'h00);
      rd(`ADDR_DEVICE_INFO, `DEVICE_INFO_VALUE);
      rd(8'h05, 8'h00);
      $display("test reset done");
      // Leave shutdown with random channel enables
      m = 8'($urandom);
      m[0] = 1'b0;
      wr(`ADDR_MODE_CONTROL, m);
      check(pd, 1'b0);
      check({chan.left_enable, chan.right_enable}, m[7:6]);
      @(negedge clock);
      for (int i = 0; i < 4; i++) begin
         n = 0;
         while (limit !== i && n < 20) begin
            @(negedge clock);
            n++;
         end
         check(limit, 8'(i));
         check(8'(n), (i == 0) ? 8'h00 : 8'(STEP_C));
         check(ss_active, 8'(i < 3));
      end
      repeat (2 * STEP_C) @(negedge clock);
      check(limit, 8'h03);
      check(ss_active, 1'b0);
      $display("test soft_start done");
      // Random volume, output options, thermal flag
      d = 8'($urandom);
      e = 8'($urandom);
      wr(`ADDR_VOLUME_SILENCE, d);
      wr(`ADDR_OUTPUT_OPTIONS, e);
      check({chan.left_mute, chan.right_mute}, d[7:6]);
      check(chan.distortion_reduce, e[3]);
      check({chan.volume, chan.left_hiz, chan.right_hiz}, {d[5:1], e[1:0]});
      rd(`ADDR_VOLUME_SILENCE, d & `VOLUME_WRITE_MASK);
      rd(`ADDR_OUTPUT_OPTIONS, e & `OUTPUT_WRITE_MASK);
      wr(`ADDR_MODE_CONTROL, m | 8'h02);
      rd(`ADDR_MODE_CONTROL, m & `MODE_WRITE_MASK);
      thermal = 1'b1;
      settle();
      rd(`ADDR_MODE_CONTROL, (m & `MODE_WRITE_MASK) | 8'h02);
      $display("test registers done");
      // Rail rises, hold restarts on a short peak
      above_low = 1'b1;
      settle();
      check(rail, 1'b1);
      above_low = 1'b0;
      settle();
      check(rail, 1'b1);
      above_low = 1'b1;
      @(negedge clock);
      above_low = 1'b0;
      n = 0;
      while (rail !== 1'b0 && n < 30) begin
         @(negedge clock);
         n++;
      end
      // Two cycles of pin synchroniser delay
      check(8'(n), 8'(HOLD_C + 2));
      $display("test class_g done");
      // Pulse mode switch sequence
      for (int i = 0; i < 6; i++) begin
         {at_high, peak, zero} = pins[i];
         settle();
         check(sw, swx[i]);
      end
      $display("test pulse_mode done");
      // Shutdown time, then enable without supply
      busy_run = 0;
      wr(`ADDR_MODE_CONTROL, 8'h01);
      check(8'(busy_run), 8'(SHUT_C));
      check(pd, 1'b1);
      check(limit, 8'h00);
      supply_ok = 1'b0;
      settle();
      wr(`ADDR_MODE_CONTROL, 8'h00);
      settle();
      check(limit, 8'h03);
      check(ss_active, 1'b0);
      check(8'(exp_q.size()), 8'h00);
      $display("test shutdown done");
      summarize();
   end
endmodule

// *** hp_power_ctrl.sv ***
// Power, mode and regulator switch sequencing of the headphone amplifier.
// Assumes an I2C front end delivering decoded byte writes and reads on
// this clock, and comparator inputs from the analog regulator.
`timescale 1ns/1ps
`include "hp_power_defs.svh"

module hp_power_ctrl #(
   parameter int SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES,
   parameter int STEP_CYCLES     = `STEP_CYCLES,
   parameter int HOLD_CYCLES     = `HOLD_CYCLES
) (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              srst,
   // Register access from the I2C front end
   input  wire logic                              write_strobe,
   input  wire logic                              read_strobe,
   input  wire logic [7:0]                        reg_address,
   input  wire logic [7:0]                        write_data,
   output logic      [7:0]                        read_data,
   output logic                                   busy,
   // Analog status pins
   input  wire logic                              thermal_active_pin,
   input  wire logic                              supply_ok_pin,
   input  wire logic                              output_above_low_pin,
   input  wire logic                              output_at_high_pin,
   input  wire logic                              pulse_mode_peak_current,
   input  wire logic                              zero_current_pin,
   // Controls to the analog side
   output logic                                   global_power_down,
   output hp_power_pkg::channel_ctrl_type         channel_ctrl,
   output logic                                   high_rail_select,
   output hp_power_pkg::current_limit_type        current_limit,
   output logic                                   soft_start_active,
   output hp_power_pkg::switch_drive_type         switch_drive
);
   default clocking main_cb @(posedge clock);
   endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   assign pin_raw = {thermal_active_pin, supply_ok_pin, output_above_low_pin,
                     output_at_high_pin, pulse_mode_peak_current,
                     zero_current_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (srst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   logic thermal_s, supply_s, above_low_s, at_high_s, peak_s, zero_s;
   assign {thermal_s, supply_s, above_low_s, at_high_s, peak_s, zero_s} =
      sync2_reg;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] mode_control_reg;
   logic [7:0] volume_and_silence_reg;
   logic [7:0] output_options_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         mode_control_reg       <= `MODE_RESET;
         volume_and_silence_reg <= `VOLUME_RESET;
         output_options_reg     <= `OUTPUT_RESET;
      end else if (write_strobe && !busy) begin
         case (reg_address)
            `ADDR_MODE_CONTROL:
               mode_control_reg <= write_data & `MODE_WRITE_MASK;
            `ADDR_VOLUME_SILENCE:
               volume_and_silence_reg <= write_data & `VOLUME_WRITE_MASK;
            `ADDR_OUTPUT_OPTIONS:
               output_options_reg <= write_data & `OUTPUT_WRITE_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         read_data <= 8'h00;
      end else if (read_strobe) begin
         case (reg_address)
            `ADDR_MODE_CONTROL: begin
               read_data <= mode_control_reg;
               read_data[`BIT_THERMAL_FLAG] <= thermal_s;
            end
            `ADDR_VOLUME_SILENCE: read_data <= volume_and_silence_reg;
            `ADDR_OUTPUT_OPTIONS: read_data <= output_options_reg;
            `ADDR_DEVICE_INFO:    read_data <= `DEVICE_INFO_VALUE;
            default:              read_data <= 8'h00;
         endcase
      end
   end

   assign global_power_down = mode_control_reg[`BIT_POWER_DOWN];

   always_comb begin
      channel_ctrl.left_enable  = mode_control_reg[`BIT_LEFT_ENABLE];
      channel_ctrl.right_enable = mode_control_reg[`BIT_RIGHT_ENABLE];
      channel_ctrl.left_mute    = volume_and_silence_reg[`BIT_LEFT_MUTE];
      channel_ctrl.right_mute   = volume_and_silence_reg[`BIT_RIGHT_MUTE];
      channel_ctrl.left_hiz     = output_options_reg[`BIT_HIZ_LEFT];
      channel_ctrl.right_hiz    = output_options_reg[`BIT_HIZ_RIGHT];
      channel_ctrl.distortion_reduce =
         output_options_reg[`BIT_DISTORTION_REDUCE];
      channel_ctrl.volume       = volume_and_silence_reg[5:1];
   end

   ////////////////////////////////////////////////////////////////////////
   // Shutdown timer: blocks writes while the shutdown sequence runs
   logic [31:0] shutdown_count_reg;
   logic        power_down_prev_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         power_down_prev_reg <= 1'b1;
      end else begin
         power_down_prev_reg <= global_power_down;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         shutdown_count_reg <= 32'h0;
      end else if (global_power_down && !power_down_prev_reg) begin
         shutdown_count_reg <= 32'(SHUTDOWN_CYCLES);
      end else if (shutdown_count_reg != 32'h0) begin
         shutdown_count_reg <= shutdown_count_reg - 32'h1;
      end
   end

   assign busy = (shutdown_count_reg != 32'h0);

   ////////////////////////////////////////////////////////////////////////
   // Soft start
   logic [31:0] step_count_reg;
   logic        enable_edge;
   assign enable_edge = power_down_prev_reg && !global_power_down;

   always_ff @(posedge clock) begin
      if (srst) begin
         current_limit     <= hp_power_pkg::limit_70ma;
         soft_start_active <= 1'b0;
         step_count_reg    <= 32'h0;
      end else if (global_power_down) begin
         current_limit     <= hp_power_pkg::limit_70ma;
         soft_start_active <= 1'b0;
         step_count_reg    <= 32'h0;
      end else if (enable_edge) begin
         if (supply_s) begin
            current_limit     <= hp_power_pkg::limit_70ma;
            soft_start_active <= 1'b1;
            step_count_reg    <= 32'(STEP_CYCLES);
         end else begin
            current_limit     <= hp_power_pkg::limit_750ma;
            soft_start_active <= 1'b0;
         end
      end else if (soft_start_active) begin
         if (step_count_reg > 32'h1) begin
            step_count_reg <= step_count_reg - 32'h1;
         end else begin
            step_count_reg <= 32'(STEP_CYCLES);
            case (current_limit)
               hp_power_pkg::limit_70ma:
                  current_limit <= hp_power_pkg::limit_140ma;
               hp_power_pkg::limit_140ma:
                  current_limit <= hp_power_pkg::limit_280ma;
               hp_power_pkg::limit_280ma: begin
                  current_limit     <= hp_power_pkg::limit_750ma;
                  soft_start_active <= 1'b0;
               end
               default: soft_start_active <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Class G rail selection
   logic [31:0] hold_count_reg;

   always_ff @(posedge clock) begin
      if (srst || global_power_down) begin
         high_rail_select <= 1'b0;
         hold_count_reg   <= 32'h0;
      end else if (above_low_s) begin
         high_rail_select <= 1'b1;
         hold_count_reg   <= 32'(HOLD_CYCLES);
      end else if (high_rail_select) begin
         if (hold_count_reg > 32'h1) begin
            hold_count_reg <= hold_count_reg - 32'h1;
         end else begin
            high_rail_select <= 1'b0;
            hold_count_reg   <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse-frequency mode switch sequencer
   hp_power_pkg::pulse_state_type pulse_state_reg;

   always_ff @(posedge clock) begin
      if (srst || global_power_down) begin
         pulse_state_reg <= hp_power_pkg::pulse_idle;
      end else begin
         case (pulse_state_reg)
            hp_power_pkg::pulse_idle:
               if (!at_high_s) begin
                  pulse_state_reg <= hp_power_pkg::pulse_high_on;
               end
            hp_power_pkg::pulse_high_on:
               if (at_high_s) begin
                  pulse_state_reg <= hp_power_pkg::pulse_discharge;
               end else if (peak_s) begin
                  pulse_state_reg <= hp_power_pkg::pulse_low_on;
               end
            hp_power_pkg::pulse_low_on:
               if (zero_s) begin
                  pulse_state_reg <= at_high_s ?
                     hp_power_pkg::pulse_idle :
                     hp_power_pkg::pulse_high_on;
               end else if (at_high_s) begin
                  pulse_state_reg <= hp_power_pkg::pulse_discharge;
               end
            hp_power_pkg::pulse_discharge:
               if (zero_s) begin
                  pulse_state_reg <= hp_power_pkg::pulse_idle;
               end
            default: pulse_state_reg <= hp_power_pkg::pulse_idle;
         endcase
      end
   end

   always_comb begin
      switch_drive.high_side_on   =
         (pulse_state_reg == hp_power_pkg::pulse_high_on);
      switch_drive.low_side_on    =
         (pulse_state_reg == hp_power_pkg::pulse_low_on) ||
         (pulse_state_reg == hp_power_pkg::pulse_discharge);
      switch_drive.idle_low_power =
         (pulse_state_reg == hp_power_pkg::pulse_idle);
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_power_down_rise;
      global_power_down && !power_down_prev_reg;
   endsequence

   a_switch_exclusive: assert property (
      !(switch_drive.high_side_on && switch_drive.low_side_on))
      else $error("both switches on");

   a_busy_after_down: assert property (
      s_power_down_rise |=> busy [*8])
      else $error("writes not blocked after power down");

   a_write_mode: assert property (
      write_strobe && !busy && reg_address == `ADDR_MODE_CONTROL |=>
      global_power_down == $past(write_data[`BIT_POWER_DOWN]))
      else $error("power down bit not written");

   a_write_enable: assert property (
      write_strobe && !busy && reg_address == `ADDR_MODE_CONTROL |=>
      channel_ctrl.left_enable == $past(write_data[`BIT_LEFT_ENABLE]) &&
      channel_ctrl.right_enable == $past(write_data[`BIT_RIGHT_ENABLE]))
      else $error("enable bits not written");

   a_write_mute: assert property (
      write_strobe && !busy && reg_address == `ADDR_VOLUME_SILENCE |=>
      channel_ctrl.left_mute == $past(write_data[`BIT_LEFT_MUTE]) &&
      channel_ctrl.right_mute == $past(write_data[`BIT_RIGHT_MUTE]))
      else $error("mute bit not written");

   a_thermal_read: assert property (
      read_strobe && reg_address == `ADDR_MODE_CONTROL |=>
      read_data[`BIT_THERMAL_FLAG] == $past(thermal_s))
      else $error("thermal flag misread");

   a_rail_rise: assert property (
      above_low_s && !global_power_down |=> high_rail_select)
      else $error("rail did not rise");

   a_rail_holds: assert property (
      $fell(high_rail_select) && !global_power_down |->
      !$past(above_low_s) && $past(hold_count_reg) == 32'h1)
      else $error("rail fell before hold expired");

   a_limit_order: assert property (
      soft_start_active && current_limit != $past(current_limit) &&
      !$past(enable_edge) |-> current_limit == $past(current_limit) + 2'h1)
      else $error("current limit step out of order");

   a_soft_start_gate: assert property (
      enable_edge && !supply_s |=> !soft_start_active)
      else $error("soft start without supply");

endmodule

// *** hp_power_defs.svh ***
// Register offsets, bit positions, reset values and timing for the
// headphone amplifier power and mode controller.
// Assumes inclusion by bare name from the bench, the host model and the design file.
`ifndef HP_POWER_DEFS_SVH
`define HP_POWER_DEFS_SVH

`define ADDR_MODE_CONTROL      8'h01
`define ADDR_VOLUME_SILENCE    8'h02
`define ADDR_OUTPUT_OPTIONS    8'h03
`define ADDR_DEVICE_INFO       8'h04

`define BIT_POWER_DOWN         0
`define BIT_THERMAL_FLAG       1
`define BIT_RIGHT_ENABLE       6
`define BIT_LEFT_ENABLE        7
`define BIT_RIGHT_MUTE         6
`define BIT_LEFT_MUTE          7
`define BIT_DISTORTION_REDUCE  3
`define BIT_HIZ_LEFT           1
`define BIT_HIZ_RIGHT          0

`define MODE_WRITE_MASK        8'hc1
`define VOLUME_WRITE_MASK      8'hfe
`define OUTPUT_WRITE_MASK      8'h0b
`define MODE_RESET             8'h01
`define VOLUME_RESET           8'hc0
`define OUTPUT_RESET           8'h00
// Device information value, arbitrary
`define DEVICE_INFO_VALUE      8'h5a

`define SHUTDOWN_TIME_MS       3
`define CLOCK_MHZ              250
`define SHUTDOWN_CYCLES        (`SHUTDOWN_TIME_MS * 1000 * `CLOCK_MHZ)
`define STEP_TIME_US           60
`define STEP_CYCLES            (`STEP_TIME_US * `CLOCK_MHZ)
`define HOLD_TIME_US           100
`define HOLD_CYCLES            (`HOLD_TIME_US * `CLOCK_MHZ)

`endif

// *** hp_power_pkg.sv ***
// Types for the headphone amplifier power and mode controller.
// Assumes the defines header is compiled alongside.
package hp_power_pkg;

   // Soft-start current limit step: 70, 140, 280, 750 mA
   typedef enum logic [1:0] {
      limit_70ma,
      limit_140ma,
      limit_280ma,
      limit_750ma
   } current_limit_type;

   typedef enum logic [1:0] {
      pulse_idle,
      pulse_high_on,
      pulse_low_on,
      pulse_discharge
   } pulse_state_type;

   typedef struct packed {
      logic high_side_on;
      logic low_side_on;
      logic idle_low_power;
   } switch_drive_type;

   typedef struct packed {
      logic left_enable;
      logic right_enable;
      logic left_mute;
      logic right_mute;
      logic left_hiz;
      logic right_hiz;
      logic distortion_reduce;
      logic [4:0] volume;
   } channel_ctrl_type;

endpackage

// *** reg_host_model.sv ***
// Host model issuing single-byte register writes and reads.
// Assumes the controller samples strobes on the rising clock edge.
`timescale 1ns/1ps
`include "hp_power_defs.svh"

module reg_host_model (
   // Clock
   input  wire logic       clock,
   // Register access
   output logic            write_strobe,
   output logic            read_strobe,
   output logic [7:0]      reg_address,
   output logic [7:0]      write_data,
   input  wire logic       busy
);
   initial begin
      write_strobe = 1'b0;
      read_strobe  = 1'b0;
      reg_address  = 8'h00;
      write_data   = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic access(input logic wr, input logic [7:0] a, d);
      @(negedge clock);
      while (busy !== 1'b0) @(negedge clock);
      reg_address  = a;
      write_data   = d;
      write_strobe = wr;
      read_strobe  = !wr;
      @(negedge clock);
      write_strobe = 1'b0;
      read_strobe  = 1'b0;
      // Released lines show the inverse
      reg_address  = ~a;
      write_data   = ~d;
      // No command until shutdown completes
      if (wr && a == `ADDR_MODE_CONTROL && d[0]) begin
         repeat (3) @(negedge clock);
         while (busy !== 1'b0) @(negedge clock);
      end
   endtask
endmodule
